// ### hw/hls_defines.vh
// head load sequencer constants: register map, field positions, reset values, timing
// assumes a 40 MHz system clock and 32-bit AHB-Lite data
`ifndef HLS_DEFINES_VH
`define HLS_DEFINES_VH

// register byte offsets
`define HLS_CTRL_OFS 8'h00
`define HLS_STATUS_OFS 8'h04
`define HLS_NEW_CYL_OFS 8'h08
`define HLS_PRESENT_CYL_OFS 8'h0C

// control register fields
`define HLS_CTRL_LOAD_EN_BIT 0
`define HLS_CTRL_CLR_TIMEOUT_BIT 1
`define HLS_CTRL_SET_SEEK_CHECK_BIT 2
`define HLS_CTRL_RESET 32'h0000_0001

// status register fields
`define HLS_ST_BUSY_BIT 0
`define HLS_ST_DRIVE_READY_BIT 1
`define HLS_ST_SEEK_CHECK_BIT 2
`define HLS_ST_TIMEOUT_BIT 3
`define HLS_ST_SEEK_HOME_BIT 4
`define HLS_ST_SERVO_EN_BIT 5
`define HLS_ST_AMP_EN_BIT 6
`define HLS_ST_MATCH_BIT 7
`define HLS_ST_STATE_LSB 8

// cylinder address
`define HLS_CYL_W 10
`define HLS_HOME_CYL 10'h000

// timing
`define HLS_CLK_HZ 40000000
`define HLS_TIMEOUT_MS 1667
`define HLS_AMP_DELAY_MS 60
`define HLS_MS_PER_S 1000

`endif

// ### hw/hls_sync2.v
// two-flop synchroniser for a bundle of pin levels
// assumes each bit is an independent slow level
`timescale 1ns/100ps
module hls_sync2 #(
  parameter WIDTH = 1
) (
  input wire ref_clk_in,
  input wire reset_in,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta;

  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      meta <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule // hls_sync2

// ### hw/hls_tick_div.v
// divider giving a one-cycle enable pulse every PERIOD clocks
// assumes PERIOD of at least 2
`timescale 1ns/100ps
module hls_tick_div #(
  parameter PERIOD = 40000,
  parameter W = 16
) (
  input wire ref_clk_in,
  input wire reset_in,
  output reg tick_out
);
  localparam [W-1:0] LAST = PERIOD[W-1:0] - 1'b1;
  reg [W-1:0] count;

  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      count <= {W{1'b0}};
      tick_out <= 1'b0;
    end else begin
      tick_out <= (count == LAST);
      if (count == LAST) begin
        count <= {W{1'b0}};
      end else begin
        count <= count + 1'b1;
      end
    end
  end
endmodule // hls_tick_div

// ### hw/hls_head_load.v
// head load sequencer: interlock check, head release, seek home, relay and amp timing
// assumes an AHB-Lite master on ref_clk_in; all drive pins are asynchronous levels
`timescale 1ns/100ps
`include "hls_defines.vh"
module hls_head_load #(
  parameter CLK_PER_MS = `HLS_CLK_HZ / `HLS_MS_PER_S,
  parameter TIMEOUT_MS = `HLS_TIMEOUT_MS,
  parameter AMP_DELAY_MS = `HLS_AMP_DELAY_MS
) (
  input wire ref_clk_in,
  input wire reset_in,
  // AHB-Lite slave
  input wire hsel_in,
  input wire [31:0] haddr_in,
  input wire [1:0] htrans_in,
  input wire hwrite_in,
  input wire [2:0] hsize_in,
  input wire [31:0] hwdata_in,
  input wire hready_in,
  output reg [31:0] hrdata_out,
  output reg hreadyout_out,
  output reg hresp_out,
  // drive interlocks and sensors
  input wire pack_present_n_in,
  input wire access_door_latched_n_in,
  input wire run_stop_stop_in,
  input wire gain_ctrl_fault_in,
  input wire carriage_back_fault_in,
  input wire interlock_fault_in,
  input wire destructive_write_fault_in,
  input wire spindle_at_speed_n_in,
  input wire drive_ready_in,
  input wire supply_fault_n_in,
  input wire gain_valid_in,
  input wire heads_settled_in,
  input wire track_step_in,
  // actuator and servo side
  output reg head_withdraw_cmd_out,
  output reg home_seek_active_n_out,
  output reg track_reset_pulse_out,
  output reg offset_clear_n_out,
  output reg carriage_release_enable_out,
  output reg latch_solenoid_drive_n_out,
  output reg servo_loop_on_n_out,
  output reg motor_relay_on_out,
  output reg motor_amp_enable_out,
  output reg cyl_match_out,
  output reg fwd_slew_out,
  output reg timeout_fault_out
);
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_LOAD = 2'h1;
  localparam [1:0] ST_SETTLED = 2'h2;
  localparam CW = `HLS_CYL_W;
  localparam [10:0] TIMEOUT_LAST = TIMEOUT_MS[10:0] - 11'h001;
  localparam [6:0] AMP_LAST = AMP_DELAY_MS[6:0];

  // synchronised pins
  wire [12:0] pins_sync;
  wire pack_ok = ~pins_sync[0];
  wire door_ok = ~pins_sync[1];
  wire stopped = pins_sync[2];
  wire any_ext_fault = |pins_sync[6:3];
  wire spindle_up = ~pins_sync[7];
  wire drive_ready = pins_sync[8];
  wire supply_ok = pins_sync[9];
  wire gain_valid = pins_sync[10];
  wire settled = pins_sync[11];
  wire track_step = pins_sync[12];

  hls_sync2 #(.WIDTH(13)) u_sync (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .async_in({track_step_in, heads_settled_in, gain_valid_in, supply_fault_n_in,
      drive_ready_in, spindle_at_speed_n_in, destructive_write_fault_in,
      interlock_fault_in, carriage_back_fault_in, gain_ctrl_fault_in,
      run_stop_stop_in, access_door_latched_n_in, pack_present_n_in}),
    .sync_out(pins_sync)
  );

  // synced pins read as stale zeros for two edges after reset
  reg [1:0] sync_warm;

  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      sync_warm <= 2'h0;
    end else begin
      sync_warm <= {sync_warm[0], 1'b1};
    end
  end

  wire ms_tick;
  hls_tick_div #(.PERIOD(CLK_PER_MS), .W(32)) u_ms (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .tick_out(ms_tick)
  );

  // sequencer state
  reg [1:0] state;
  reg [1:0] next_state;
  reg withdraw;
  reg servo_en;
  reg seek_home;
  reg timeout_fault;
  reg seek_check;
  reg timer_run;
  reg [10:0] timer_ms;
  reg [6:0] amp_ms;
  reg amp_en;
  reg gain_valid_d;
  reg track_step_d;
  reg [CW-1:0] new_cyl;
  reg [CW-1:0] present_cyl;
  reg load_en;

  // register bus decode
  reg wr_pend;
  reg [7:0] wr_addr;
  wire bus_take = hsel_in & htrans_in[1] & hready_in;
  wire wr_ctrl = wr_pend & (wr_addr == `HLS_CTRL_OFS);
  wire wr_cyl = wr_pend & (wr_addr == `HLS_NEW_CYL_OFS);
  wire clr_timeout = wr_ctrl & hwdata_in[`HLS_CTRL_CLR_TIMEOUT_BIT];
  wire set_seek_check = wr_ctrl & hwdata_in[`HLS_CTRL_SET_SEEK_CHECK_BIT];

  wire load_ok = pack_ok & door_ok & ~stopped & ~any_ext_fault & ~timeout_fault
    & load_en & sync_warm[1];
  wire start_load = (state == ST_IDLE) & load_ok & spindle_up;
  wire gain_rise = gain_valid & ~gain_valid_d;
  wire timer_expire = timer_run & ms_tick & (timer_ms == TIMEOUT_LAST);

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_load) begin
          next_state = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (~load_ok | timer_expire) begin
          next_state = ST_IDLE;
        end else if (settled & ~seek_home) begin
          next_state = ST_SETTLED;
        end
      end
      ST_SETTLED: begin
        if (~load_ok) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state <= ST_IDLE;
      withdraw <= 1'b1;
      servo_en <= 1'b0;
      seek_home <= 1'b0;
      timer_run <= 1'b0;
      timer_ms <= 11'h000;
      timeout_fault <= 1'b0;
      gain_valid_d <= 1'b0;
      track_step_d <= 1'b0;
    end else begin
      state <= next_state;
      gain_valid_d <= gain_valid;
      track_step_d <= track_step;
      if (next_state == ST_IDLE) begin
        withdraw <= 1'b1;
        servo_en <= 1'b0;
        seek_home <= 1'b0;
      end else if (start_load) begin
        withdraw <= 1'b0;
        servo_en <= 1'b1;
        seek_home <= 1'b1;
      end else if (gain_rise) begin
        seek_home <= 1'b0;
      end
      // timeout interval
      if (start_load) begin
        timer_run <= 1'b1;
        timer_ms <= 11'h000;
      end else if (timer_expire | (next_state != ST_LOAD)) begin
        timer_run <= 1'b0;
      end else if (timer_run & ms_tick) begin
        timer_ms <= timer_ms + 11'h001;
      end
      // expiry wins over a software clear in the same cycle
      if (timer_expire) begin
        timeout_fault <= 1'b1;
      end else if (clr_timeout) begin
        timeout_fault <= 1'b0;
      end
    end
  end

  // relay settle delay before amp enable
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      amp_ms <= 7'h00;
      amp_en <= 1'b0;
    end else if (~servo_en) begin
      amp_ms <= 7'h00;
      amp_en <= 1'b0;
    end else if (ms_tick & ~amp_en) begin
      if (amp_ms == AMP_LAST - 7'h01) begin
        amp_en <= 1'b1;
      end
      amp_ms <= amp_ms + 7'h01;
    end
  end

  // seek check and cylinder addresses
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      seek_check <= 1'b0;
      new_cyl <= `HLS_HOME_CYL;
      present_cyl <= `HLS_HOME_CYL;
    end else begin
      if (set_seek_check) begin
        seek_check <= 1'b1;
      end else if (seek_home) begin
        seek_check <= 1'b0;
      end
      if (seek_home) begin
        new_cyl <= `HLS_HOME_CYL;
        present_cyl <= `HLS_HOME_CYL;
      end else begin
        if (wr_cyl) begin
          new_cyl <= hwdata_in[CW-1:0];
        end
        if (track_step & ~track_step_d) begin
          present_cyl <= present_cyl + 1'b1;
        end
      end
    end
  end

  // registered outputs toward the actuator and servo
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      head_withdraw_cmd_out <= 1'b1;
      home_seek_active_n_out <= 1'b1;
      track_reset_pulse_out <= 1'b0;
      offset_clear_n_out <= 1'b1;
      carriage_release_enable_out <= 1'b0;
      latch_solenoid_drive_n_out <= 1'b1;
      servo_loop_on_n_out <= 1'b1;
      motor_relay_on_out <= 1'b0;
      motor_amp_enable_out <= 1'b0;
      cyl_match_out <= 1'b1;
      fwd_slew_out <= 1'b0;
      timeout_fault_out <= 1'b0;
    end else begin
      head_withdraw_cmd_out <= withdraw;
      home_seek_active_n_out <= ~seek_home;
      track_reset_pulse_out <= seek_home;
      offset_clear_n_out <= ~seek_home;
      carriage_release_enable_out <= servo_en & ~drive_ready & ~withdraw;
      latch_solenoid_drive_n_out <= ~(servo_en & ~drive_ready & ~withdraw);
      servo_loop_on_n_out <= ~servo_en;
      motor_relay_on_out <= servo_en & supply_ok;
      motor_amp_enable_out <= amp_en;
      cyl_match_out <= (new_cyl == present_cyl);
      fwd_slew_out <= seek_home & ~gain_valid & ~gain_rise;
      timeout_fault_out <= timeout_fault;
    end
  end

  // AHB-Lite slave, zero wait states, always OKAY
  reg [31:0] next_rdata;
  wire [7:0] rd_addr = haddr_in[7:0];

  always @* begin
    next_rdata = 32'h0000_0000;
    case (rd_addr)
      `HLS_CTRL_OFS: begin
        next_rdata[`HLS_CTRL_LOAD_EN_BIT] = load_en;
      end
      `HLS_STATUS_OFS: begin
        next_rdata[`HLS_ST_BUSY_BIT] = (state == ST_LOAD);
        next_rdata[`HLS_ST_DRIVE_READY_BIT] = drive_ready;
        next_rdata[`HLS_ST_SEEK_CHECK_BIT] = seek_check;
        next_rdata[`HLS_ST_TIMEOUT_BIT] = timeout_fault;
        next_rdata[`HLS_ST_SEEK_HOME_BIT] = seek_home;
        next_rdata[`HLS_ST_SERVO_EN_BIT] = servo_en;
        next_rdata[`HLS_ST_AMP_EN_BIT] = amp_en;
        next_rdata[`HLS_ST_MATCH_BIT] = (new_cyl == present_cyl);
        next_rdata[`HLS_ST_STATE_LSB+1:`HLS_ST_STATE_LSB] = state;
      end
      `HLS_NEW_CYL_OFS: begin
        next_rdata[CW-1:0] = new_cyl;
      end
      `HLS_PRESENT_CYL_OFS: begin
        next_rdata[CW-1:0] = present_cyl;
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata_out <= 32'h0000_0000;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
      load_en <= 1'b1;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
      wr_pend <= bus_take & hwrite_in & (haddr_in[31:8] == 24'h000000);
      wr_addr <= rd_addr;
      if (bus_take & ~hwrite_in) begin
        hrdata_out <= (haddr_in[31:8] == 24'h000000) ? next_rdata : 32'h0000_0000;
      end
      if (wr_ctrl) begin
        load_en <= hwdata_in[`HLS_CTRL_LOAD_EN_BIT];
      end
    end
  end
endmodule // hls_head_load

// ### bench/hls_head_load_sva.sv
// checker for the head load sequencer pins
// assumes binding onto hls_head_load with the same timing parameters
`timescale 1ns/100ps
module hls_head_load_chk #(
  parameter CLK_PER_MS = 40000,
  parameter TIMEOUT_MS = 1667,
  parameter AMP_DELAY_MS = 60
) (
  input wire ref_clk_in,
  input wire reset_in,
  input wire run_stop_stop_in,
  input wire spindle_at_speed_n_in,
  input wire gain_valid_in,
  input wire head_withdraw_cmd_out,
  input wire home_seek_active_n_out,
  input wire track_reset_pulse_out,
  input wire offset_clear_n_out,
  input wire carriage_release_enable_out,
  input wire latch_solenoid_drive_n_out,
  input wire servo_loop_on_n_out,
  input wire motor_relay_on_out,
  input wire motor_amp_enable_out,
  input wire cyl_match_out,
  input wire fwd_slew_out,
  input wire timeout_fault_out
);
  localparam int AMP_MIN = CLK_PER_MS * (AMP_DELAY_MS - 1) - 2;
  localparam int AMP_MAX = CLK_PER_MS * (AMP_DELAY_MS + 1) + 6;
  localparam int TO_MIN = CLK_PER_MS * (TIMEOUT_MS - 1) - 2;
  // cycles since the servo loop came on
  logic [31:0] on_cnt;
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in)
      on_cnt <= 32'h0000_0000;
    else if (servo_loop_on_n_out)
      on_cnt <= 32'h0000_0000;
    else
      on_cnt <= on_cnt + 32'h0000_0001;
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  load_cond_a: assert property (
    $fell(head_withdraw_cmd_out) |-> !$past(spindle_at_speed_n_in, 4)
      && !$past(run_stop_stop_in, 4))
    else $error("head withdraw dropped without load conditions");
  seek_start_a: assert property (
    $fell(home_seek_active_n_out) |-> !head_withdraw_cmd_out ##[0:1] !servo_loop_on_n_out)
    else $error("seek home began without release and servo");
  seek_side_a: assert property (
    track_reset_pulse_out == !home_seek_active_n_out && offset_clear_n_out == home_seek_active_n_out)
    else $error("track reset or offset clear out of step with seek home");
  release_gate_a: assert property (
    $rose(carriage_release_enable_out) |-> !servo_loop_on_n_out && !head_withdraw_cmd_out)
    else $error("carriage release without servo on");
  latch_drive_a: assert property (
    latch_solenoid_drive_n_out == !carriage_release_enable_out)
    else $error("latch solenoid drive not inverse of release");
  relay_gate_a: assert property (
    $rose(motor_relay_on_out) |-> !servo_loop_on_n_out)
    else $error("relay on without servo loop");
  amp_early_a: assert property (
    motor_amp_enable_out |-> on_cnt >= AMP_MIN)
    else $error("amp enabled too soon");
  amp_late_a: assert property (
    on_cnt == AMP_MAX |-> motor_amp_enable_out)
    else $error("amp enable late");
  home_match_a: assert property (
    !home_seek_active_n_out [*3] |-> cyl_match_out)
    else $error("no match during seek home");
  slew_gate_a: assert property (
    fwd_slew_out |-> !home_seek_active_n_out)
    else $error("slew outside seek home");
  gain_stop_a: assert property (
    $rose(gain_valid_in) && !home_seek_active_n_out |-> ##[1:5] home_seek_active_n_out && !fwd_slew_out)
    else $error("gain valid did not end seek home");
  timeout_set_a: assert property (
    $rose(timeout_fault_out) |-> on_cnt >= TO_MIN ##[0:3] head_withdraw_cmd_out)
    else $error("timeout fault early or heads not withdrawn");
endmodule // hls_head_load_chk

bind hls_head_load hls_head_load_chk #(.CLK_PER_MS(CLK_PER_MS), .TIMEOUT_MS(TIMEOUT_MS),
  .AMP_DELAY_MS(AMP_DELAY_MS)) chk_u (.ref_clk_in, .reset_in, .run_stop_stop_in,
  .spindle_at_speed_n_in, .gain_valid_in, .head_withdraw_cmd_out, .home_seek_active_n_out,
  .track_reset_pulse_out, .offset_clear_n_out, .carriage_release_enable_out,
  .latch_solenoid_drive_n_out, .servo_loop_on_n_out, .motor_relay_on_out,
  .motor_amp_enable_out, .cyl_match_out, .fwd_slew_out, .timeout_fault_out);

// ### bench/hls_carriage_model.sv
// behavioural carriage, latch solenoid and servo loop
// assumes the sequencer clock; distances are counted in clock cycles
`timescale 1ns/100ps
module hls_carriage_model #(
  parameter int SLEW_CYC = 40,
  parameter int SETTLE_CYC = 12
) (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic slew_in,
  input wire logic latch_n_in,
  input wire logic relay_in,
  input wire logic amp_in,
  input wire logic withdraw_in,
  input wire logic stall_in,
  output logic gain_valid_out,
  output logic settled_out,
  output logic ready_out
);
  int pos;
  int settle;
  always @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in || withdraw_in) begin
      pos <= 0;
      settle <= 0;
      gain_valid_out <= 1'b0;
      settled_out <= 1'b0;
      ready_out <= 1'b0;
    end else begin
      // carriage moves only with latch freed and relay closed
      if (slew_in && !latch_n_in && relay_in && !stall_in)
        pos <= pos + 1;
      gain_valid_out <= (pos >= SLEW_CYC);
      if (gain_valid_out && amp_in)
        settle <= settle + 1;
      settled_out <= (settle >= SETTLE_CYC);
      ready_out <= settled_out;
    end
  end
endmodule // hls_carriage_model

// ### bench/testbench.sv
// self-checking bench for the head load sequencer
// assumes shortened timing: 10 clocks a tick, 20 tick timeout, 3 tick amp delay
`timescale 1ns/100ps
module testbench;
  logic ref_clk_in, reset_in, hsel_in, hwrite_in, hreadyout_out, hresp_out;
  logic [31:0] haddr_in, hwdata_in, hrdata_out, rd;
  logic [1:0] htrans_in;
  logic [2:0] hsize_in;
  logic [7:0] pin_v;
  logic pack_present_n_in, access_door_latched_n_in, run_stop_stop_in, gain_ctrl_fault_in;
  logic carriage_back_fault_in, interlock_fault_in, destructive_write_fault_in;
  logic spindle_at_speed_n_in, drive_ready_in, supply_fault_n_in, gain_valid_in;
  logic heads_settled_in, track_step_in, stall;
  logic head_withdraw_cmd_out, home_seek_active_n_out, track_reset_pulse_out, offset_clear_n_out;
  logic carriage_release_enable_out, latch_solenoid_drive_n_out, servo_loop_on_n_out;
  logic motor_relay_on_out, motor_amp_enable_out, cyl_match_out, fwd_slew_out, timeout_fault_out;
  int mismatches = 0;
  int tests_run = 0;
  // pins, then expected withdraw and servo_n
  logic [9:0] rows [0:8] = '{10'h203, 10'h103, 10'h083, 10'h043, 10'h023, 10'h013,
    10'h00B, 10'h007, 10'h000};
  assign {pack_present_n_in, access_door_latched_n_in, run_stop_stop_in, gain_ctrl_fault_in,
    carriage_back_fault_in, interlock_fault_in, destructive_write_fault_in,
    spindle_at_speed_n_in} = pin_v;
  hls_head_load #(.CLK_PER_MS(10), .TIMEOUT_MS(20), .AMP_DELAY_MS(3)) dut_u (
    .ref_clk_in, .reset_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in, .hwdata_in,
    .hready_in(hreadyout_out), .hrdata_out, .hreadyout_out, .hresp_out, .pack_present_n_in,
    .access_door_latched_n_in, .run_stop_stop_in, .gain_ctrl_fault_in, .carriage_back_fault_in,
    .interlock_fault_in, .destructive_write_fault_in, .spindle_at_speed_n_in, .drive_ready_in,
    .supply_fault_n_in, .gain_valid_in, .heads_settled_in, .track_step_in,
    .head_withdraw_cmd_out, .home_seek_active_n_out, .track_reset_pulse_out,
    .offset_clear_n_out, .carriage_release_enable_out, .latch_solenoid_drive_n_out,
    .servo_loop_on_n_out, .motor_relay_on_out, .motor_amp_enable_out, .cyl_match_out,
    .fwd_slew_out, .timeout_fault_out);
  hls_carriage_model model_u (.ref_clk_in, .reset_in, .slew_in(fwd_slew_out),
    .latch_n_in(latch_solenoid_drive_n_out), .relay_in(motor_relay_on_out),
    .amp_in(motor_amp_enable_out), .withdraw_in(head_withdraw_cmd_out), .stall_in(stall),
    .gain_valid_out(gain_valid_in), .settled_out(heads_settled_in), .ready_out(drive_ready_in));
  task automatic wrap_up();
    if (mismatches == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge ref_clk_in);
    hsel_in <= 1'b1;
    htrans_in <= 2'h2;
    haddr_in <= a;
    hwrite_in <= wr;
    do @(posedge ref_clk_in); while (hreadyout_out !== 1'b1);
    hsel_in <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= wd;
    do @(posedge ref_clk_in); while (hreadyout_out !== 1'b1);
    rd = hrdata_out;
  endtask
  initial begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    cyc(6000);
    mismatches++;
    wrap_up();
  end
  initial begin
    {reset_in, hsel_in, hwrite_in, htrans_in, haddr_in, hwdata_in} = {3'h4, 66'h0};
    hsize_in = 3'h2;
    pin_v = 8'h81;
    supply_fault_n_in = 1'b1;
    track_step_in = 1'b0;
    stall = 1'b0;
    cyc(12);
    reset_in <= 1'b0;
    chk(head_withdraw_cmd_out, 1);
    chk(motor_amp_enable_out, 0);
    bus(0, 32'h00, 0);
    chk(rd, 32'h1);
    bus(1, 32'h08, 32'h5);
    bus(1, 32'h00, 32'h5);
    bus(0, 32'h04, 0);
    chk(rd[2], 1);
    chk({hreadyout_out, hresp_out}, 2'h2);
    chk(cyl_match_out, 0);
    for (int i = 0; i < 9; i++) begin
      cyc(1);
      pin_v <= rows[i][9:2];
      cyc(8);
      chk(head_withdraw_cmd_out, rows[i][1]);
      chk(servo_loop_on_n_out, rows[i][0]);
    end
    chk(fwd_slew_out, 1);
    chk(offset_clear_n_out, 0);
    chk(track_reset_pulse_out, 1);
    chk(carriage_release_enable_out, 1);
    chk(latch_solenoid_drive_n_out, 0);
    chk(motor_relay_on_out, 1);
    bus(0, 32'h08, 0);
    chk(rd[9:0], 0);
    chk(cyl_match_out, 1);
    bus(0, 32'h04, 0);
    chk(rd[2], 0);
    supply_fault_n_in <= 1'b0;
    cyc(5);
    chk(motor_relay_on_out, 0);
    supply_fault_n_in <= 1'b1;
    for (int n = 0; n < 300 && drive_ready_in !== 1'b1; n++) cyc(1);
    chk(motor_amp_enable_out, 1);
    chk(home_seek_active_n_out, 1);
    chk(fwd_slew_out, 0);
    cyc(4);
    chk(carriage_release_enable_out, 0);
    chk(latch_solenoid_drive_n_out, 1);
    cyc(250);
    chk(timeout_fault_out, 0);
    chk(head_withdraw_cmd_out, 0);
    bus(1, 32'h08, 32'h2);
    cyc(3);
    chk(cyl_match_out, 0);
    repeat (2) begin
      track_step_in <= 1'b1;
      cyc(3);
      track_step_in <= 1'b0;
      cyc(3);
    end
    chk(cyl_match_out, 1);
    bus(0, 32'h0C, 0);
    chk(rd[9:0], 2);
    bus(0, 32'h20, 0);
    chk(rd, 0);
    pin_v <= 8'h20;
    cyc(10);
    chk(head_withdraw_cmd_out, 1);
    stall <= 1'b1;
    pin_v <= 8'h00;
    cyc(260);
    chk(timeout_fault_out, 1);
    chk(head_withdraw_cmd_out, 1);
    cyc(20);
    chk(head_withdraw_cmd_out, 1);
    // clear the fault with loading disabled, then enable
    bus(1, 32'h00, 32'h2);
    cyc(10);
    chk(timeout_fault_out, 0);
    chk(head_withdraw_cmd_out, 1);
    bus(1, 32'h00, 32'h1);
    cyc(10);
    chk(head_withdraw_cmd_out, 0);
    // reset in mid-load: no false start while the synchroniser refills
    reset_in <= 1'b1;
    cyc(2);
    chk(head_withdraw_cmd_out, 1);
    chk(servo_loop_on_n_out, 1);
    reset_in <= 1'b0;
    cyc(3);
    chk(head_withdraw_cmd_out, 1);
    cyc(6);
    chk(head_withdraw_cmd_out, 0);
    wrap_up();
  end
endmodule // testbench
